// file: verilog/fault_irq_pkg.sv
// constants for the fault record, interrupt and power-disable block
// assumes a single 40 MHz clock and an Avalon-MM register slave
//
// What this block does
// - rail fault sets its sticky flag immediately
// - rail flag stays set after fault clears
// - flag read returns value, clears if gone
// - record captures top, rail status, flag faults
// - writing one clears a recorded fault
// - record holds until cleared or undervoltage lockout
// - masked recorded fault never drives interrupt
// - unmasked recorded fault drives interrupt line low
// - disable falling never reloads fuse defaults
// - disable low, supply good: power up now
// - disable assertion delayed before power off
// - delay select: 0 to 16 ms
// - select seven ignores power-disable input
// - status bits track live condition
package fault_irq_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int RAILS      = 6;
  localparam int TOP_BITS   = 8;
  localparam int REC_BITS   = TOP_BITS + 2 * RAILS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TOP_STATUS  = 8'h00;
  localparam logic [7:0] OFS_RAIL_STATUS = 8'h04;
  localparam logic [7:0] OFS_RAIL_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_FAULT_REC   = 8'h0c;
  localparam logic [7:0] OFS_FAULT_MASK  = 8'h10;
  localparam logic [7:0] OFS_PWR_CTRL    = 8'h14;
  localparam logic [7:0] OFS_PWR_STATE   = 8'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int REC_TOP_LSB   = 0;
  localparam int REC_PG_LSB    = TOP_BITS;
  localparam int REC_FLAG_LSB  = TOP_BITS + RAILS;
  localparam int SEL_W         = 3;
  localparam logic [REC_BITS-1:0] MASK_RST = 20'h00000;
  localparam logic [SEL_W-1:0]    SEL_RST  = 3'h0;
  localparam logic [SEL_W-1:0]    SEL_IGNORE = 3'h7;
  localparam int PST_ENABLE    = 0;
  localparam int PST_PENDING   = 1;

  // ----------------------------------------------------------------
  // timing: delay counted in half-millisecond ticks
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS  = 500000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int MAX_TICKS     = 32;
  localparam int FUSE_LOAD_CYC = 3;

  // delay in ticks for a select code: 0 or 7 -> none, other n -> 2^(n-1)
  function automatic logic [6:0] sel_ticks(input logic [SEL_W-1:0] sel);
    logic [6:0] t;
    t = 7'h00;
    if (sel != 3'h0 && sel != SEL_IGNORE)
      t = 7'(7'h01 << (sel - 3'h1));
    return t;
  endfunction

endpackage

// file: verilog/pwr_ctl_if.sv
// carrier between the register block and the power-off delay timer
// assumes both ends share ref_clk
interface pwr_ctl_if;
  logic [fault_irq_pkg::SEL_W-1:0] delay_sel;
  logic                            disable_req;
  logic                            supply_ok;
  logic                            power_enable;
  logic                            off_pending;
  logic                            up_start;
  logic                            off_start;

  modport ctrl  (output delay_sel, disable_req, supply_ok,
                 input  power_enable, off_pending, up_start, off_start);
  modport timer (input  delay_sel, disable_req, supply_ok,
                 output power_enable, off_pending, up_start, off_start);
endinterface

// file: verilog/sync2.sv
// two-stage synchroniser for a bundle of slow levels
// assumes each bit changes slowly compared to ref_clk
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // the first stage is read only by the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sync2

// file: verilog/power_off_timer.sv
// power enable state with the selectable power-off delay
// assumes synchronised inputs and a select that changes rarely
module power_off_timer #(
  parameter int TICK_CYCLES = fault_irq_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control bundle
  pwr_ctl_if.timer  p
);
  typedef enum logic [2:0] {
    ST_OFF     = 3'b001,
    ST_ON      = 3'b010,
    ST_PENDING = 3'b100
  } pstate_t;

  pstate_t     state_r, state_nxt;
  logic [31:0] cyc_r, cyc_nxt;
  logic [6:0]  tick_r, tick_nxt;
  logic        up_nxt, off_nxt;
  logic        dis_eff;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  // select seven makes the disable input invisible
  assign dis_eff = p.disable_req && (p.delay_sel != fault_irq_pkg::SEL_IGNORE);

  // next state and delay counting
  always_comb begin
    state_nxt = state_r;
    cyc_nxt   = cyc_r;
    tick_nxt  = tick_r;
    up_nxt    = 1'b0;
    off_nxt   = 1'b0;
    case (state_r)
      ST_OFF: begin
        if (p.supply_ok && !dis_eff) begin
          state_nxt = ST_ON;
          up_nxt    = 1'b1;
        end
      end
      ST_ON: begin
        if (!p.supply_ok) begin
          state_nxt = ST_OFF;
          off_nxt   = 1'b1;
        end else if (dis_eff) begin
          cyc_nxt  = 32'h0;
          tick_nxt = 7'h00;
          if (fault_irq_pkg::sel_ticks(p.delay_sel) == 7'h00) begin
            state_nxt = ST_OFF;
            off_nxt   = 1'b1;
          end else begin
            state_nxt = ST_PENDING;
          end
        end
      end
      ST_PENDING: begin
        if (!p.supply_ok) begin
          state_nxt = ST_OFF;
          off_nxt   = 1'b1;
        end else if (!dis_eff) begin
          state_nxt = ST_ON;
        end else if (tick_r >= fault_irq_pkg::sel_ticks(p.delay_sel)) begin
          state_nxt = ST_OFF;
          off_nxt   = 1'b1;
        end else if (cyc_r == 32'(TICK_CYCLES - 1)) begin
          cyc_nxt  = 32'h0;
          tick_nxt = tick_r + 7'h01;
        end else begin
          cyc_nxt = cyc_r + 32'h1;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  // registers; outputs come straight from flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r        <= ST_OFF;
      cyc_r          <= 32'h0;
      tick_r         <= 7'h00;
      p.up_start     <= 1'b0;
      p.off_start    <= 1'b0;
      p.power_enable <= 1'b0;
      p.off_pending  <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      cyc_r          <= cyc_nxt;
      tick_r         <= tick_nxt;
      p.up_start     <= up_nxt;
      p.off_start    <= off_nxt;
      p.power_enable <= (state_nxt != ST_OFF);
      p.off_pending  <= (state_nxt == ST_PENDING);
    end
  end
endmodule // power_off_timer

// file: verilog/fault_irq_top.sv
// fault flags, fault record, interrupt and power-disable handling
// assumes pins are asynchronous to ref_clk; registers over Avalon-MM
module fault_irq_top #(
  parameter int TICK_CYCLES = fault_irq_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               rst,
  // avalon-mm slave
  input  wire logic [7:0]                         address,
  input  wire logic                               read,
  input  wire logic                               write,
  input  wire logic [31:0]                        writedata,
  output logic      [31:0]                        readdata,
  output logic                                    waitrequest,
  // monitored conditions
  input  wire logic [fault_irq_pkg::RAILS-1:0]    rail_fault_event,
  input  wire logic [fault_irq_pkg::RAILS-1:0]    rail_power_good,
  input  wire logic [fault_irq_pkg::TOP_BITS-1:0] top_fault_in,
  input  wire logic                               input_supply_ok,
  input  wire logic                               undervoltage_lockout,
  // power control
  input  wire logic                               power_disable_in,
  input  wire logic [fault_irq_pkg::SEL_W-1:0]    fuse_defaults,
  output logic                                    power_enable,
  output logic                                    power_up_start,
  output logic                                    power_off_start,
  // interrupt
  output logic                                    irq,
  output logic                                    interrupt_line_low
);
  localparam int RAILS = fault_irq_pkg::RAILS;
  localparam int TOPB  = fault_irq_pkg::TOP_BITS;
  localparam int RECB  = fault_irq_pkg::REC_BITS;
  localparam int SELW  = fault_irq_pkg::SEL_W;
  localparam int SYNW  = 2 * RAILS + TOPB + 4 + SELW;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // rising edge of a bundle between two samples
  function automatic logic [RAILS-1:0] rise6(input logic [RAILS-1:0] cur,
                                             input logic [RAILS-1:0] prev);
    return cur & ~prev;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [RAILS-1:0] evt_s, pg_s;
  logic [TOPB-1:0]  top_s;
  logic             supply_s, undervoltage_lockout_s, dis_s, spare_s;
  logic [SELW-1:0]  fuse_s;
  logic [SYNW-1:0]  sync_q;

  // every outside level passes two flops before any logic
  sync2 #(
    .WIDTH (SYNW)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({rail_fault_event, rail_power_good, top_fault_in, input_supply_ok,
               undervoltage_lockout, power_disable_in, 1'b0, fuse_defaults}),
    .q       (sync_q)
  );

  assign {evt_s, pg_s, top_s, supply_s, undervoltage_lockout_s, dis_s, spare_s, fuse_s} = sync_q;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic        wait_nxt;
  logic [31:0] rdata_nxt;
  logic        acc_rd, acc_wr;

  // a request is taken at the edge where waitrequest is seen low
  assign acc_rd = read && !waitrequest;
  assign acc_wr = write && !waitrequest;

  // one wait cycle per request, then a single acknowledge cycle
  always_comb begin
    wait_nxt = 1'b1;
    if ((read || write) && waitrequest)
      wait_nxt = 1'b0;
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [RECB-1:0] mask_r, mask_nxt;
  logic [SELW-1:0] sel_r, sel_nxt;
  logic [1:0]      fuse_cnt_r, fuse_cnt_nxt;
  logic            fuse_done_r, fuse_done_nxt;

  // fuse values are taken once after reset; a falling disable input
  // does not touch them, so software settings survive power cycling
  always_comb begin
    mask_nxt      = mask_r;
    sel_nxt       = sel_r;
    fuse_cnt_nxt  = fuse_cnt_r;
    fuse_done_nxt = fuse_done_r;
    if (!fuse_done_r) begin
      if (fuse_cnt_r == 2'(fault_irq_pkg::FUSE_LOAD_CYC - 1)) begin
        sel_nxt       = fuse_s;
        fuse_done_nxt = 1'b1;
      end else begin
        fuse_cnt_nxt = fuse_cnt_r + 2'h1;
      end
    end
    if (acc_wr && address == fault_irq_pkg::OFS_FAULT_MASK)
      mask_nxt = writedata[RECB-1:0];
    if (acc_wr && address == fault_irq_pkg::OFS_PWR_CTRL)
      sel_nxt = writedata[SELW-1:0];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r      <= fault_irq_pkg::MASK_RST;
      sel_r       <= fault_irq_pkg::SEL_RST;
      fuse_cnt_r  <= 2'h0;
      fuse_done_r <= 1'b0;
    end else begin
      mask_r      <= mask_nxt;
      sel_r       <= sel_nxt;
      fuse_cnt_r  <= fuse_cnt_nxt;
      fuse_done_r <= fuse_done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // sticky rail fault flags
  // ----------------------------------------------------------------
  logic [RAILS-1:0] flag_r, flag_nxt;
  logic             flag_rd;

  assign flag_rd = acc_rd && address == fault_irq_pkg::OFS_RAIL_FLAGS;

  // set while the event is present, so a live event beats the read clear
  always_comb begin
    flag_nxt = flag_r;
    if (flag_rd)
      flag_nxt = flag_r & evt_s;
    flag_nxt = flag_nxt | evt_s;
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      flag_r <= '0;
    else
      flag_r <= flag_nxt;
  end

  // ----------------------------------------------------------------
  // fault record and interrupt
  // ----------------------------------------------------------------
  logic [RECB-1:0]  rec_r, rec_nxt, rec_set;
  logic [TOPB-1:0]  top_prev_r;
  logic [RAILS-1:0] pg_prev_r, flag_prev_r;
  logic             irq_nxt;

  // edge capture per source: top fault rising, power good lost,
  // rail flag rising
  always_comb begin
    rec_set = '0;
    rec_set[fault_irq_pkg::REC_TOP_LSB +: TOPB]   = top_s & ~top_prev_r;
    rec_set[fault_irq_pkg::REC_PG_LSB +: RAILS]   = rise6(~pg_s, ~pg_prev_r);
    rec_set[fault_irq_pkg::REC_FLAG_LSB +: RAILS] = rise6(flag_r, flag_prev_r);
  end

  // clears first, then sets, so an event in a clear cycle is kept
  always_comb begin
    rec_nxt = rec_r;
    if (undervoltage_lockout_s)
      rec_nxt = '0;
    else if (acc_wr && address == fault_irq_pkg::OFS_FAULT_REC)
      rec_nxt = rec_r & ~writedata[RECB-1:0];
    rec_nxt = rec_nxt | rec_set;
    irq_nxt = |(rec_nxt & ~mask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rec_r              <= '0;
      top_prev_r         <= '0;
      pg_prev_r          <= '0;
      flag_prev_r        <= '0;
      irq                <= 1'b0;
      interrupt_line_low <= 1'b1;
    end else begin
      rec_r              <= rec_nxt;
      top_prev_r         <= top_s;
      pg_prev_r          <= pg_s;
      flag_prev_r        <= flag_r;
      irq                <= irq_nxt;
      interrupt_line_low <= !irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power-off delay timer
  // ----------------------------------------------------------------
  pwr_ctl_if pc ();

  assign pc.delay_sel   = sel_r;
  assign pc.disable_req = dis_s;
  assign pc.supply_ok   = supply_s && !undervoltage_lockout_s;

  power_off_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .p       (pc.timer)
  );

  // timer outputs are flops inside the timer
  assign power_enable    = pc.power_enable;
  assign power_up_start  = pc.up_start;
  assign power_off_start = pc.off_start;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // status reads are live, not latched
  always_comb begin
    rdata_nxt = 32'h0;
    if (read && waitrequest) begin
      case (address)
        fault_irq_pkg::OFS_TOP_STATUS:  rdata_nxt[TOPB-1:0]  = top_s;
        fault_irq_pkg::OFS_RAIL_STATUS: rdata_nxt[RAILS-1:0] = pg_s;
        fault_irq_pkg::OFS_RAIL_FLAGS:  rdata_nxt[RAILS-1:0] = flag_r;
        fault_irq_pkg::OFS_FAULT_REC:   rdata_nxt[RECB-1:0]  = rec_r;
        fault_irq_pkg::OFS_FAULT_MASK:  rdata_nxt[RECB-1:0]  = mask_r;
        fault_irq_pkg::OFS_PWR_CTRL:    rdata_nxt[SELW-1:0]  = sel_r;
        fault_irq_pkg::OFS_PWR_STATE: begin
          rdata_nxt[fault_irq_pkg::PST_ENABLE]  = pc.power_enable;
          rdata_nxt[fault_irq_pkg::PST_PENDING] = pc.off_pending;
        end
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else begin
      waitrequest <= wait_nxt;
      readdata    <= rdata_nxt;
    end
  end

endmodule // fault_irq_top

// file: bench/fault_irq_checker.sv
// concurrent checks on the ports of the fault record, interrupt and power block
// assumes it is bound to fault_irq_top and runs on ref_clk with rst
module fault_irq_checker #(
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // bus side
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // monitored pins
  input wire logic [7:0]  top_fault_in,
  input wire logic [5:0]  rail_fault_event,
  input wire logic [5:0]  rail_power_good,
  input wire logic        input_supply_ok,
  input wire logic        undervoltage_lockout,
  input wire logic        power_disable_in,
  // outputs under check
  input wire logic        power_enable,
  input wire logic        power_up_start,
  input wire logic        power_off_start,
  input wire logic        irq,
  input wire logic        interrupt_line_low
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  a_req_answered: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered next cycle");
  a_ack_one_cycle: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_rdata_idle_zero: assert property (waitrequest |-> readdata == 32'h0)
    else $error("readdata not zero outside acknowledge");
  // ------------------------------------------------------------
  // interrupt and power
  // ------------------------------------------------------------
  a_line_inverse: assert property (interrupt_line_low != irq)
    else $error("interrupt line not inverse of irq");
  a_up_pulse: assert property ($rose(power_enable) |-> power_up_start)
    else $error("power up without start pulse");
  a_off_pulse: assert property ($fell(power_enable) |-> power_off_start)
    else $error("power off without start pulse");
  // a power-off needs a cause seen at the pins three samples earlier:
  // two synchroniser stages plus the timer's own register
  a_off_has_cause: assert property ($fell(power_enable) |->
    $past(power_disable_in, 3) || !$past(input_supply_ok, 3) || $past(undervoltage_lockout, 3))
    else $error("power off with no disable request and supply good");
  a_up_when_free: assert property (
    (!power_disable_in && input_supply_ok && !undervoltage_lockout) [*8] |-> power_enable)
    else $error("power not up with disable low and supply good");
  a_lockout_clears: assert property (
    (undervoltage_lockout && $stable(top_fault_in) && $stable(rail_fault_event)
     && $stable(rail_power_good)) [*7] |-> !irq && !power_enable)
    else $error("lockout did not clear record and power");
  cover property (power_off_start);
  cover property (power_up_start);
  cover property (read && !waitrequest);
  cover property ($rose(irq));
endmodule // fault_irq_checker

bind fault_irq_top fault_irq_checker #(.TICK_CYCLES(TICK_CYCLES)) fault_irq_checker_i (
  .ref_clk, .rst, .read, .write, .readdata, .waitrequest, .top_fault_in, .rail_fault_event,
  .rail_power_good, .input_supply_ok, .undervoltage_lockout, .power_disable_in,
  .power_enable, .power_up_start, .power_off_start, .irq, .interrupt_line_low);

// file: bench/host_asic_model.sv
// model of the host controller that drives the power-disable pin
// assumes the bench raises want_off when it wants the rails off
module host_asic_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // bench command
  input  wire logic want_off,
  // pin toward the device
  output logic      power_disable_in = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // a clean registered level; held low in reset so the rails may come up
  always @(posedge ref_clk) begin
    if (rst) begin
      power_disable_in <= 1'b0;
    end else begin
      power_disable_in <= want_off;
    end
  end
endmodule // host_asic_model

// file: bench/test_fault_flag_irq_and_power_disable.sv
// self-checking bench for fault_irq_top with a host model on power-disable
// assumes the package, interface and design modules are compiled first
module test_fault_flag_irq_and_power_disable;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, want_off = 1'b0;
  logic        input_supply_ok = 1'b1, undervoltage_lockout = 1'b0, power_disable_in;
  logic        waitrequest, irq, interrupt_line_low, power_enable, power_up_start;
  logic        power_off_start;
  logic [7:0]  address = 8'h00, top_fault_in = 8'h00, tf;
  logic [5:0]  rail_fault_event = 6'h00, rail_power_good = 6'h3f;
  logic [2:0]  fuse_defaults = 3'h2;
  logic [31:0] writedata = 32'h0, readdata, exp, v;
  logic [31:0] exp_q[$];
  int          n_errors = 0, comparisons = 0, seed = 42, cycles = 0, n, t;

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  fault_irq_top #(.TICK_CYCLES(4)) fault_irq_top_i (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rail_fault_event(rail_fault_event), .rail_power_good(rail_power_good),
    .top_fault_in(top_fault_in), .input_supply_ok(input_supply_ok),
    .undervoltage_lockout(undervoltage_lockout), .power_disable_in(power_disable_in),
    .fuse_defaults(fuse_defaults), .power_enable(power_enable),
    .power_up_start(power_up_start), .power_off_start(power_off_start), .irq(irq),
    .interrupt_line_low(interrupt_line_low));

  host_asic_model host_asic_model_i (
    .ref_clk(ref_clk), .rst(rst), .want_off(want_off), .power_disable_in(power_disable_in));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one avalon access; held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // read results are compared at the acknowledge edge, oldest note first
  always @(posedge ref_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      exp = exp_q.pop_front();
      chk("readdata", exp, readdata);
    end
  end

  // a hang counts as a mismatch; the whole run needs about 1100 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(6);
    // reset values, fuse load, unmapped place
    rd(fault_irq_pkg::OFS_FAULT_MASK, 32'h0);
    rd(fault_irq_pkg::OFS_PWR_CTRL, 32'h2);
    acc(1'b1, 8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    rd(fault_irq_pkg::OFS_PWR_STATE, 32'h1);
    // random top faults: live status, record, mask, clear
    v = $random(seed);
    tf = v[7:0] | 8'h01;
    @(posedge ref_clk);
    top_fault_in <= tf;
    cyc(5);
    rd(fault_irq_pkg::OFS_TOP_STATUS, {24'h0, tf});
    rd(fault_irq_pkg::OFS_FAULT_REC, {24'h0, tf});
    chk("interrupt_line_low", 32'h0, 32'(interrupt_line_low));
    acc(1'b1, fault_irq_pkg::OFS_FAULT_MASK, 32'h000fffff);
    cyc(3);
    chk("irq", 32'h0, 32'(irq));
    acc(1'b1, fault_irq_pkg::OFS_FAULT_MASK, 32'h0);
    cyc(3);
    chk("irq", 32'h1, 32'(irq));
    acc(1'b1, fault_irq_pkg::OFS_FAULT_REC, 32'h000fffff);
    cyc(3);
    rd(fault_irq_pkg::OFS_FAULT_REC, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    // sticky rail flags: two gone, one still present
    top_fault_in <= 8'h00;
    rail_fault_event <= 6'h05;
    cyc(5);
    @(posedge ref_clk);
    rail_fault_event <= 6'h02;
    cyc(5);
    rd(fault_irq_pkg::OFS_RAIL_FLAGS, 32'h07);
    rd(fault_irq_pkg::OFS_RAIL_FLAGS, 32'h02);
    rail_fault_event <= 6'h00;
    rail_power_good <= 6'h3c;
    cyc(5);
    rd(fault_irq_pkg::OFS_RAIL_FLAGS, 32'h02);
    rd(fault_irq_pkg::OFS_RAIL_FLAGS, 32'h00);
    rd(fault_irq_pkg::OFS_RAIL_STATUS, 32'h3c);
    rd(fault_irq_pkg::OFS_FAULT_REC, 32'h1c300);
    // lockout and supply loss wipe the record and drop power
    rail_power_good <= 6'h3f;
    undervoltage_lockout <= 1'b1;
    input_supply_ok <= 1'b0;
    cyc(8);
    @(posedge ref_clk);
    undervoltage_lockout <= 1'b0;
    input_supply_ok <= 1'b1;
    cyc(12);
    rd(fault_irq_pkg::OFS_FAULT_REC, 32'h0);
    chk("power_enable", 32'h1, 32'(power_enable));
    // every delay select code, ticks of 4 cycles in this bench
    for (int s = 0; s < 8; s++) begin
      acc(1'b1, fault_irq_pkg::OFS_PWR_CTRL, 32'(s));
      t = (s == 0) ? 0 : (1 << (s - 1));
      @(posedge ref_clk);
      want_off <= 1'b1;
      n = 0;
      while (power_enable !== 1'b0 && n < 300) begin
        @(posedge ref_clk);
        n++;
      end
      if (s == 7)
        chk("power_enable", 32'h1, 32'(power_enable));
      else
        chk("off_delay", 32'h1, 32'(n >= t * 4 && n <= t * 4 + 12));
      want_off <= 1'b0;
      cyc(10);
      chk("power_enable", 32'h1, 32'(power_enable));
    end
    rd(fault_irq_pkg::OFS_PWR_CTRL, 32'h7);
    // disable dropped while the longest delay is pending
    acc(1'b1, fault_irq_pkg::OFS_PWR_CTRL, 32'h6);
    want_off <= 1'b1;
    cyc(40);
    rd(fault_irq_pkg::OFS_PWR_STATE, 32'h3);
    want_off <= 1'b0;
    cyc(200);
    rd(fault_irq_pkg::OFS_PWR_STATE, 32'h1);
    cyc(4);
    end_of_test();
  end
endmodule // test_fault_flag_irq_and_power_disable
